// >>> servo_homing_controller.v
// Servo homing controller with APB register access
`include "homing_consts.vh"
module servo_homing_controller #(
  parameter MS_CYC = `MS_CYCLES
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Pins
  input wire fwd_travel_limit_in,
  input wire rev_travel_limit_in,
  input wire homing_trigger_in,
  input wire home_switch_in,
  input wire index_pulse_in,
  input wire servo_enabled_in,
  input wire signed [31:0] encoder_pos_in,
  // Motion command
  output reg signed [16:0] speed_cmd_out,
  output reg [15:0] ramp_time_out,
  output reg homing_done_out,
  output reg homing_busy_out,
  output reg signed [31:0] zero_point_out,
  output reg irq
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_FAST = 5'b00010;
  localparam [4:0] S_SLOW = 5'b00100;
  localparam [4:0] S_INDEX = 5'b01000;
  localparam [4:0] S_DONE = 5'b10000;

  function synced;
    input [2:0] s;
    input prev;
    begin
      synced = (s[1] == s[2]) ? s[1] : prev;
    end
  endfunction

  function in_run;
    input [4:0] st;
    begin
      in_run = (st == S_FAST) || (st == S_SLOW) || (st == S_INDEX);
    end
  endfunction

  function [31:0] unit_scale;
    input [1:0] u;
    begin
      case (u)
        2'd1: unit_scale = 32'h0000_000A;
        2'd2: unit_scale = 32'h0000_0064;
        default: unit_scale = 32'h0000_0001;
      endcase
    end
  endfunction

  function index_method;
    input [3:0] m;
    begin
      index_method = (m == 4'd2) || (m == 4'd3) || (m == 4'd6) || (m == 4'd7) ||
        (m >= 4'd8);
    end
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [2:0] fl_s;
  reg [2:0] rl_s;
  reg [2:0] tr_s;
  reg [2:0] hs_s;
  reg [2:0] ix_s;
  reg fl_r;
  reg rl_r;
  reg tr_r;
  reg hs_r;
  reg ix_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_s <= 3'b000;
      rl_s <= 3'b000;
      tr_s <= 3'b000;
      hs_s <= 3'b000;
      ix_s <= 3'b000;
      fl_r <= 1'b0;
      rl_r <= 1'b0;
      tr_r <= 1'b0;
      hs_r <= 1'b0;
      ix_r <= 1'b0;
    end else begin
      fl_s <= {fl_s[1:0], fwd_travel_limit_in};
      rl_s <= {rl_s[1:0], rev_travel_limit_in};
      tr_s <= {tr_s[1:0], homing_trigger_in};
      hs_s <= {hs_s[1:0], home_switch_in};
      ix_s <= {ix_s[1:0], index_pulse_in};
      fl_r <= synced(fl_s, fl_r);
      rl_r <= synced(rl_s, rl_r);
      tr_r <= synced(tr_s, tr_r);
      hs_r <= synced(hs_s, hs_r);
      ix_r <= synced(ix_s, ix_r);
    end
  end
  // Delayed copies for edge detection
  reg fl_d;
  reg rl_d;
  reg tr_d;
  reg hs_d;
  reg ix_d;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_d <= 1'b0;
      rl_d <= 1'b0;
      tr_d <= 1'b0;
      hs_d <= 1'b0;
      ix_d <= 1'b0;
    end else begin
      fl_d <= fl_r;
      rl_d <= rl_r;
      tr_d <= tr_r;
      hs_d <= hs_r;
      ix_d <= ix_r;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [15:0] ctrl_mode_r;
  reg [15:0] home_cfg_r;
  reg [15:0] high_spd_r;
  reg [15:0] low_spd_r;
  reg [15:0] ramp_r;
  reg [15:0] abs_mt_r;
  reg [15:0] timeout_r;
  reg [31:0] offset_r;
  reg [31:0] abs_st_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_mask_r;
  reg sw_start_r;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  wire [2:0] control_mode_field = ctrl_mode_r[2:0];
  wire [2:0] homing_enable_field = home_cfg_r[`CFG_EN_LSB+2:`CFG_EN_LSB];
  wire [3:0] homing_method_field = home_cfg_r[`CFG_METH_LSB+3:`CFG_METH_LSB];
  wire [1:0] homing_trigger_field = home_cfg_r[`CFG_TRIG_LSB+1:`CFG_TRIG_LSB];
  wire [1:0] homing_timeout_unit_field = home_cfg_r[`CFG_UNIT_LSB+1:`CFG_UNIT_LSB];
  wire pos_mode = (control_mode_field == 3'd0);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire wr_en = psel && penable && pwrite && pready;
  wire rd_en = psel && !penable && !pwrite;
  wire known = (paddr[1:0] == 2'b00) && (paddr <= `OFS_ZERO);

  // ----------------------------------------
  // Homing state machine
  // ----------------------------------------
  reg [4:0] state_r;
  reg dir_rev_r;
  reg touched_r;
  reg [31:0] tmo_cnt_r;
  reg [31:0] tick_r;
  reg [31:0] ms_left_r;
  reg pwr_armed_r;
  reg ev_ok;
  reg ev_fail;
  reg ev_start;

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  // Methods 2,3,6,7 use index pulse as reference; 0,1 switch; 4,5 limit; 8..10 index only
  wire use_index = index_method(homing_method_field);
  wire meth_rev = homing_method_field[0];
  wire lim_src = (homing_method_field >= 4'd4) && (homing_method_field <= 4'd7);
  wire src_lvl = lim_src ? (meth_rev ? rl_r : fl_r) :
    ((homing_method_field >= 4'd8) ? ix_r : hs_r);
  wire src_prev = lim_src ? (meth_rev ? rl_d : fl_d) :
    ((homing_method_field >= 4'd8) ? ix_d : hs_d);
  wire src_rise = src_lvl && !src_prev;
  wire ix_rise = ix_r && !ix_d;
  wire trig_start = (homing_trigger_field == 2'd1) ? (tr_r && !tr_d) :
    (homing_trigger_field == 2'd2) ? (!tr_r && tr_d) :
    (homing_trigger_field == 2'd0) ? !tr_r : tr_r;
  wire trig_stop = (homing_trigger_field == 2'd0) ? tr_r :
    (homing_trigger_field == 2'd3) ? !tr_r : 1'b0;
  wire meth_ok = homing_method_field <= `MAX_METHOD;
  wire start_req = pos_mode && meth_ok && !in_run(state_r) &&
    (((homing_enable_field == 3'd1) && trig_start) ||
    ((homing_enable_field == 3'd2) && pwr_armed_r && servo_enabled_in) ||
    ((homing_enable_field == 3'd3) && sw_start_r));
  wire set_here = pos_mode && (homing_enable_field == 3'd4) && sw_start_r;

  // ----------------------------------------
  // Timeout and motion guards
  // ----------------------------------------
  wire [31:0] tmo_limit = {16'h0000, timeout_r} * unit_scale(homing_timeout_unit_field);
  wire running = in_run(state_r);
  wire fwd_blk = fl_r && !dir_rev_r;
  wire rev_blk = rl_r && dir_rev_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      dir_rev_r <= 1'b0;
      touched_r <= 1'b0;
      tmo_cnt_r <= 32'h0000_0000;
      tick_r <= 32'h0000_0000;
      pwr_armed_r <= 1'b1;
      homing_done_out <= 1'b0;
      homing_busy_out <= 1'b0;
      zero_point_out <= 32'h0000_0000;
      speed_cmd_out <= 17'h0_0000;
      ramp_time_out <= `RST_RAMP;
      ev_ok <= 1'b0;
      ev_fail <= 1'b0;
      ev_start <= 1'b0;
    end else begin
      ev_ok <= 1'b0;
      ev_fail <= 1'b0;
      ev_start <= 1'b0;
      ramp_time_out <= ramp_r;
      if (start_req) begin
        state_r <= S_FAST;
        dir_rev_r <= meth_rev;
        touched_r <= 1'b0;
        tmo_cnt_r <= 32'h0000_0000;
        tick_r <= 32'h0000_0000;
        pwr_armed_r <= 1'b0;
        homing_done_out <= 1'b0;
        homing_busy_out <= 1'b1;
        ev_start <= 1'b1;
      end else if (set_here) begin
        homing_done_out <= 1'b1;
        zero_point_out <= encoder_pos_in + offset_r;
        ev_ok <= 1'b1;
      end else if (running) begin
        if (tick_r >= MS_CYC - 1) begin
          tick_r <= 32'h0000_0000;
          tmo_cnt_r <= tmo_cnt_r + 32'd1;
        end else begin
          tick_r <= tick_r + 32'd1;
        end
        if (!pos_mode || trig_stop || (tmo_cnt_r >= tmo_limit)) begin
          state_r <= S_IDLE;
          homing_done_out <= 1'b0;
          homing_busy_out <= 1'b0;
          ev_fail <= 1'b1;
        end else begin
          case (state_r)
            S_FAST: begin
              if (src_lvl && !touched_r) begin
                touched_r <= 1'b1;
                state_r <= S_SLOW;
              end else if (!lim_src && (dir_rev_r ? (rl_r && !rl_d) : (fl_r && !fl_d))) begin
                dir_rev_r <= !dir_rev_r;
              end
            end
            S_SLOW: begin
              if (src_rise || (!src_prev && src_lvl) || (src_lvl && touched_r)) begin
                state_r <= use_index ? S_INDEX : S_DONE;
              end
            end
            S_INDEX: begin
              if (ix_rise) begin
                state_r <= S_DONE;
              end
            end
            default: state_r <= S_IDLE;
          endcase
        end
      end else if (state_r == S_DONE) begin
        state_r <= S_IDLE;
        homing_done_out <= 1'b1;
        homing_busy_out <= 1'b0;
        zero_point_out <= encoder_pos_in + offset_r;
        ev_ok <= 1'b1;
      end
      if (!running || fwd_blk || rev_blk) begin
        speed_cmd_out <= 17'h0_0000;
      end else if (state_r == S_FAST) begin
        speed_cmd_out <= dir_rev_r ? -$signed({1'b0, high_spd_r}) : $signed({1'b0, high_spd_r});
      end else begin
        speed_cmd_out <= dir_rev_r ? -$signed({1'b0, low_spd_r}) : $signed({1'b0, low_spd_r});
      end
    end
  end

  // ----------------------------------------
  // APB register file
  // ----------------------------------------
  wire [2:0] ev_vec = {ev_fail, ev_ok, ev_start};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_mode_r <= `RST_CTRL_MODE;
      home_cfg_r <= `RST_HOME_CFG;
      high_spd_r <= `RST_HIGH_SPD;
      low_spd_r <= `RST_LOW_SPD;
      ramp_r <= `RST_RAMP;
      offset_r <= `RST_OFFSET;
      abs_mt_r <= 16'h0000;
      abs_st_r <= 32'h0000_0000;
      timeout_r <= `RST_TIMEOUT;
      irq_stat_r <= 3'b000;
      irq_mask_r <= 3'b000;
      sw_start_r <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
      sw_start_r <= 1'b0;
      irq <= |(irq_stat_r & irq_mask_r);
      irq_stat_r <= (irq_stat_r & ~((wr_en && paddr == `OFS_IRQ_STAT) ? pwdata[2:0] : 3'b000))
        | ev_vec;
      if (wr_en && known) begin
        case (paddr)
          `OFS_CTRL_MODE: ctrl_mode_r <= pwdata[15:0];
          `OFS_HOME_CFG: home_cfg_r <= pwdata[15:0];
          `OFS_HIGH_SPD: high_spd_r <= pwdata[15:0];
          `OFS_LOW_SPD: low_spd_r <= pwdata[15:0];
          `OFS_RAMP: ramp_r <= pwdata[15:0];
          `OFS_OFFSET: offset_r <= pwdata;
          `OFS_ABS_MT: abs_mt_r <= pwdata[15:0];
          `OFS_ABS_ST: abs_st_r <= pwdata;
          `OFS_TIMEOUT: timeout_r <= pwdata[15:0];
          `OFS_COMMAND: sw_start_r <= pwdata[0];
          `OFS_IRQ_MASK: irq_mask_r <= pwdata[2:0];
          default: sw_start_r <= 1'b0;
        endcase
      end
      if (rd_en) begin
        case (paddr)
          `OFS_CTRL_MODE: prdata <= {16'h0000, ctrl_mode_r};
          `OFS_HOME_CFG: prdata <= {16'h0000, home_cfg_r};
          `OFS_HIGH_SPD: prdata <= {16'h0000, high_spd_r};
          `OFS_LOW_SPD: prdata <= {16'h0000, low_spd_r};
          `OFS_RAMP: prdata <= {16'h0000, ramp_r};
          `OFS_OFFSET: prdata <= offset_r;
          `OFS_ABS_MT: prdata <= {16'h0000, abs_mt_r};
          `OFS_ABS_ST: prdata <= abs_st_r;
          `OFS_TIMEOUT: prdata <= {16'h0000, timeout_r};
          `OFS_STATUS: prdata <= {22'h00_0000, state_r, fl_r, rl_r, hs_r,
            homing_busy_out, homing_done_out};
          `OFS_IRQ_STAT: prdata <= {29'h0000_0000, irq_stat_r};
          `OFS_IRQ_MASK: prdata <= {29'h0000_0000, irq_mask_r};
          `OFS_POSITION: prdata <= encoder_pos_in;
          `OFS_ZERO: prdata <= zero_point_out;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// >>> homing_consts.vh
// Constants for the servo homing controller
// Notes on behaviour
// - Home reference is switch, travel limit or index pulse
// - Zero point equals reference plus signed offset
// - Homing runs only in position mode
// - High level of selected source marks home
// - High speed until first contact, then low
// - Forward limit high inhibits forward motion
// - Reverse limit high inhibits reverse motion
// - Trigger input starts homing in position mode
// - Home switch input is feedback, level or edge
// - Done output on only after success
// - Enable field selects homing start mode
// - Method codes 0 to 10, default 0
// - Trigger field selects level or edge, default 1
// - Control mode field, default position mode
`ifndef HOMING_CONSTS_VH
`define HOMING_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL_MODE 12'h000
`define OFS_HOME_CFG 12'h004
`define OFS_HIGH_SPD 12'h008
`define OFS_LOW_SPD 12'h00C
`define OFS_RAMP 12'h010
`define OFS_OFFSET 12'h014
`define OFS_ABS_MT 12'h018
`define OFS_ABS_ST 12'h01C
`define OFS_TIMEOUT 12'h020
`define OFS_COMMAND 12'h024
`define OFS_STATUS 12'h028
`define OFS_IRQ_STAT 12'h02C
`define OFS_IRQ_MASK 12'h030
`define OFS_POSITION 12'h034
`define OFS_ZERO 12'h038
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CFG_EN_LSB 0
`define CFG_METH_LSB 4
`define CFG_TRIG_LSB 8
`define CFG_UNIT_LSB 12
`define RST_CTRL_MODE 16'h0000
`define RST_HOME_CFG 16'h0100
`define RST_HIGH_SPD 16'h03E8
`define RST_LOW_SPD 16'h0064
`define RST_RAMP 16'h0BB8
`define RST_OFFSET 32'h0000_0000
`define RST_TIMEOUT 16'h2710
`define MAX_METHOD 4'hA
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 50000000
`define MS_CYCLES (`CLK_HZ / 1000)
`endif

// >>> homing_asserts.sv
// Port checker for the servo homing controller
module homing_asserts (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // Bus and motion
  input logic psel,
  input logic penable,
  input logic [11:0] paddr,
  input logic pready,
  input logic pslverr,
  input logic fwd_travel_limit_in,
  input logic rev_travel_limit_in,
  input logic signed [16:0] speed_cmd_out,
  input logic homing_done_out,
  input logic homing_busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------
  // Properties
  // --------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  a_answer_next: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_unmapped_err: assert property (psel && !penable && paddr > 12'h038 |=> pslverr)
    else $error("unmapped access not refused");
  a_fwd_inhibit: assert property (fwd_travel_limit_in [*7] |-> speed_cmd_out <= 17'sh0_0000)
    else $error("forward motion at forward limit");
  a_rev_inhibit: assert property (rev_travel_limit_in [*7] |-> speed_cmd_out >= 17'sh0_0000)
    else $error("reverse motion at reverse limit");
  a_start_clears: assert property ($rose(homing_busy_out) |-> !homing_done_out)
    else $error("done high at start of run");
  a_done_from_run: assert property ($rose(homing_done_out) |-> $past(homing_busy_out))
    else $error("done without a run");
  a_idle_still: assert property (!homing_busy_out [*3] |-> speed_cmd_out == 17'sh0_0000)
    else $error("motion outside a run");
  c_done: cover property ($rose(homing_done_out));
  c_fwd: cover property (fwd_travel_limit_in [*7]);
  c_err: cover property (pslverr);
endmodule

bind servo_homing_controller homing_asserts homing_asserts_i (.pclk, .presetn, .psel,
  .penable, .paddr, .pready, .pslverr, .fwd_travel_limit_in, .rev_travel_limit_in,
  .speed_cmd_out, .homing_done_out, .homing_busy_out);

// >>> homing_partner.sv
// Motor, encoder, travel limits and home switch model
module homing_partner #(
  parameter int HLO = 50000,
  parameter int HHI = 60000,
  parameter int LIM = 200000
) (
  // Clock and motion
  input logic pclk,
  input logic signed [16:0] speed_cmd_out,
  input logic [1:0] lim_force,
  // Sensors
  output logic fwd_travel_limit_in,
  output logic rev_travel_limit_in,
  output logic home_switch_in,
  output logic index_pulse_in,
  output logic signed [31:0] encoder_pos_in = 32'sh0000_0000
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------
  // Motion and sensors
  // --------------------
  always @(posedge pclk) begin
    encoder_pos_in <= encoder_pos_in + 32'(speed_cmd_out);
  end
  assign fwd_travel_limit_in = lim_force[0] || encoder_pos_in >= LIM;
  assign rev_travel_limit_in = lim_force[1] || encoder_pos_in <= -LIM;
  assign home_switch_in = encoder_pos_in >= HLO && encoder_pos_in <= HHI;
  assign index_pulse_in = encoder_pos_in[12:9] == 4'h0;
endmodule

// >>> tb_top.sv
// Self-checking bench for the servo homing controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic s;} row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, se, trig = 1'b0, fwd, rev, home, idx, done, busy, irq;
  logic [1:0] lim_force = 2'b00;
  logic signed [31:0] pos, zp;
  logic signed [16:0] speed;
  logic [15:0] ramp;
  int err_total = 0, compares = 0, cyc = 0, n;
  row_t rows [12] = '{'{1'b0, 12'h000, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h004, 32'h0, 32'h0100, 1'b0}, '{1'b0, 12'h008, 32'h0, 32'h03E8, 1'b0},
    '{1'b0, 12'h00C, 32'h0, 32'h0064, 1'b0}, '{1'b0, 12'h010, 32'h0, 32'h0BB8, 1'b0},
    '{1'b0, 12'h014, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h018, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h01C, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h020, 32'h0, 32'h2710, 1'b0},
    '{1'b1, 12'h014, 32'h8000_0000, 32'h8000_0000, 1'b0},
    '{1'b1, 12'h000, 32'h5, 32'h5, 1'b0}, '{1'b0, 12'h03C, 32'h0, 32'h0, 1'b1}};
  always #10 pclk = ~pclk;
  servo_homing_controller #(.MS_CYC(10)) servo_homing_controller_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .fwd_travel_limit_in(fwd), .rev_travel_limit_in(rev), .homing_trigger_in(trig),
    .home_switch_in(home), .index_pulse_in(idx), .servo_enabled_in(1'b0),
    .encoder_pos_in(pos), .speed_cmd_out(speed), .ramp_time_out(ramp),
    .homing_done_out(done), .homing_busy_out(busy), .zero_point_out(zp), .irq);
  homing_partner homing_partner_i (.pclk, .speed_cmd_out(speed), .lim_force,
    .fwd_travel_limit_in(fwd), .rev_travel_limit_in(rev), .home_switch_in(home),
    .index_pulse_in(idx), .encoder_pos_in(pos));
  // --------------------
  // Tasks
  // --------------------
  task automatic results();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(s), 32'(v));
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  // --------------------
  // Tests
  // --------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(ramp), 32'h0BB8);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (rows[i].w) apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
      chk(32'(se), 32'(rows[i].s));
    end
    $display("register table done");
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h0101);
    trig <= 1'b1;
    wait_for(busy, 1'b1, 20);
    lim_force <= 2'b01;
    repeat (8) @(posedge pclk);
    lim_force <= 2'b00;
    apb(1'b1, 12'h000, 32'h1);
    wait_for(busy, 1'b0, 20);
    chk(32'(done), 32'h0);
    $display("trigger and abort done");
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h014, 32'h10);
    apb(1'b1, 12'h020, 32'h3);
    apb(1'b1, 12'h030, 32'h2);
    apb(1'b1, 12'h004, 32'h0103);
    apb(1'b1, 12'h024, 32'h1);
    wait_for(busy, 1'b1, 10);
    @(posedge pclk);
    chk(32'(speed), 32'h03E8);
    wait_for(busy, 1'b0, 200);
    chk(32'(done), 32'h0);
    apb(1'b0, 12'h02C, 32'h0);
    chk(rd & 32'h7, 32'h5);
    chk(32'(irq), 32'h0);
    apb(1'b1, 12'h02C, 32'h7);
    apb(1'b0, 12'h02C, 32'h0);
    chk(rd, 32'h0);
    $display("timeout done");
    apb(1'b1, 12'h020, 32'h0200);
    apb(1'b1, 12'h024, 32'h1);
    wait_for(busy, 1'b1, 10);
    @(posedge pclk);
    n = 0;
    while (speed === 17'sh0_03E8 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(speed < 17'sh0_0000 ? -speed : speed), 32'h0064);
    wait_for(done, 1'b1, 3000);
    chk(32'(zp - 32'sh10 >= 50000 && zp - 32'sh10 <= 60000), 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, 12'h02C, 32'h7);
    apb(1'b0, 12'h02C, 32'h0);
    chk(32'(irq), 32'h0);
    $display("homing done");
    for (int m = 1; m < 6; m++) begin
      apb(1'b1, 12'h000, 32'(m));
      apb(1'b1, 12'h024, 32'h1);
      repeat (5) @(posedge pclk);
      chk(32'(busy), 32'h0);
    end
    $display("mode refusal done");
    results();
  end
endmodule
